// file: logic/lps_pkg.sv
// Constants and types for the low-power SDRAM host controller
package lps_pkg;

// ----------------------------------------------------------------
// Clock and time conversion
// ----------------------------------------------------------------
localparam int CLK_NS = 5;

// Least times round up
function automatic int ns_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
endfunction

// Longest times round down
function automatic int ns_max(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
endfunction

// ----------------------------------------------------------------
// Device timing
// ----------------------------------------------------------------
localparam int T_INIT_US = 200;
localparam int T_RAS_NS = 48;
localparam int T_RAS_MAX_NS = 100000;
localparam int T_RC_NS = 60;
localparam int T_RCD_NS = 18;
localparam int T_RRD_NS = 12;
localparam int T_RP_NS = 18;
localparam int T_RFC_NS = 80;
localparam int T_XSR_NS = 80;
localparam int T_REF_MS = 64;
localparam int REF_ROWS = 4096;
localparam int T_REFI_NS = T_REF_MS * 1000000 / REF_ROWS;
localparam int C_MRD = 2;
localparam int C_DPL = 2;
localparam int C_DAL = 5;
localparam int CAS_LAT = 3;

localparam int INIT_CYC = ns_min(T_INIT_US * 1000);
localparam int RAS_MAX_CYC = ns_max(T_RAS_MAX_NS);
localparam int REFI_CYC = ns_max(T_REFI_NS);

// ----------------------------------------------------------------
// Counter widths and loads (load is count minus one)
// ----------------------------------------------------------------
localparam int TW = 5;
localparam int WW = 16;
localparam int RW = 12;
localparam int NBANK = 4;
localparam int A10_BIT = 10;

localparam logic [TW-1:0] L_RC = TW'(ns_min(T_RC_NS) - 1);
localparam logic [TW-1:0] L_RAS = TW'(ns_min(T_RAS_NS) - 1);
localparam logic [TW-1:0] L_RCD = TW'(ns_min(T_RCD_NS) - 1);
localparam logic [TW-1:0] L_RRD = TW'(ns_min(T_RRD_NS) - 1);
localparam logic [TW-1:0] L_DPL = TW'(C_DPL - 1);
localparam logic [TW-1:0] L_DAL = TW'(C_DAL - 1);
localparam logic [WW-1:0] L_RP = WW'(ns_min(T_RP_NS) - 1);
localparam logic [WW-1:0] L_RFC = WW'(ns_min(T_RFC_NS) - 1);
localparam logic [WW-1:0] L_MRD = WW'(C_MRD - 1);
localparam logic [WW-1:0] L_SRMIN = WW'(ns_min(T_RAS_NS) - 1);
localparam logic [WW-1:0] L_XSR = WW'(ns_min(T_XSR_NS) - 1);
localparam logic [RW-1:0] RST_REF = RW'(REFI_CYC - 1);

// Burst length one, sequential, CAS latency in A6..A4
localparam logic [11:0] MODE_WORD = {5'h00, 3'(CAS_LAT), 4'h0};

function automatic logic [TW-1:0] tdec(input logic [TW-1:0] x);
    return (x == '0) ? x : x - TW'(1);
endfunction

// ----------------------------------------------------------------
// Types
// ----------------------------------------------------------------
// Encoded as {cs_n, ras_n, cas_n, we_n}
typedef enum logic [3:0] {
    CMD_MRS = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
    CMD_WR = 4'h4, CMD_RD = 4'h5, CMD_NOP = 4'h7
} lps_cmd_t;

typedef enum logic [3:0] {
    S_PWRUP = 4'h0, S_REF = 4'h1, S_MRS = 4'h3, S_IDLE = 4'h2,
    S_RW = 4'h6, S_PRE = 4'h7, S_SREF = 4'ha, S_SRX = 4'hb
} lps_st_t;

typedef struct packed {
    logic write;
    logic [1:0] bank;
    logic [11:0] row;
    logic [8:0] col;
    logic [31:0] wdata;
    logic [3:0] mask;
} lps_req_t;

typedef struct packed {
    logic cke;
    lps_cmd_t cmd;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [3:0] dqm;
} lps_pins_t;

typedef struct packed {
    logic [TW-1:0] rc;
    logic [TW-1:0] ras;
    logic [TW-1:0] rcd;
    logic [TW-1:0] dal;
    logic [TW-1:0] dpl;
} lps_btmr_t;

typedef struct packed {
    lps_st_t st;
    logic [WW-1:0] wait_cnt;
    logic [RW-1:0] ref_cnt;
    logic [1:0] owed;
    logic init_done;
    logic [TW-1:0] trrd;
    lps_btmr_t [NBANK-1:0] bt;
    logic [1:0] bank;
    logic write;
    lps_pins_t pins;
    logic [31:0] dq_o;
    logic dq_oe;
    logic [CAS_LAT:0] rd_pipe;
    logic [31:0] rd_data;
    logic rd_valid;
} lps_state_t;

endpackage

// file: logic/lps_ctrl.sv
// Host-side command sequencer for a four-bank low-power SDRAM
//
// Contract
// - Wait 200 us, then two refreshes
// - Overdue refresh repeats the two wake-ups
// - Only defined commands are ever driven
// - Row open between 48 ns and 100 us
// - Same-bank activates at least 60 ns apart
// - Column command 18 ns after activate
// - Activates to any banks 12 ns apart
// - Self-refresh exit waits 80 ns before activate
// - Column commands may come every cycle
// - Write data goes with write command
// - Write data to activate five cycles
// - Write data to precharge two cycles
// - Burst stop one cycle after data (none is issued: bursts are single word)
// - 4096 refreshes every 64 ms
// - Nanosecond minimums round up to cycles, maximums round down
// - Mode load to activate two cycles
`timescale 1ns/1ps
module lps_ctrl
    import lps_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire lps_req_t req,
    output logic req_ready,
    output logic [31:0] rd_data,
    output logic rd_valid,
    input wire logic sref_req,
    output logic sref_active,
    output logic init_done,
    output lps_pins_t pins,
    output logic [31:0] dq_o,
    output logic dq_oe,
    input wire logic [31:0] dq_in
);

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
lps_state_t q;
lps_state_t d;
lps_btmr_t [NBANK-1:0] bt_dec;
logic [NBANK-1:0] bank_ok;
logic [8:0] req_col_q;
logic [3:0] mask_q;

// ----------------------------------------------------------------
// Per-bank timers
// ----------------------------------------------------------------
for (genvar b = 0; b < NBANK; b++) begin : g_bank
    assign bt_dec[b].rc = tdec(q.bt[b].rc);
    assign bt_dec[b].ras = tdec(q.bt[b].ras);
    assign bt_dec[b].rcd = tdec(q.bt[b].rcd);
    assign bt_dec[b].dal = tdec(q.bt[b].dal);
    assign bt_dec[b].dpl = tdec(q.bt[b].dpl);
    // Activate gate: row cycle and write-to-activate done
    assign bank_ok[b] = (q.bt[b].rc == '0) && (q.bt[b].dal == '0);
end

// Closed page: every access is activate, one column command, precharge
assign req_ready = (q.st == S_IDLE) && (q.wait_cnt == '0) &&
                   (q.owed == 2'h0) && !sref_req &&
                   bank_ok[req.bank] && (q.trrd == '0);

// ----------------------------------------------------------------
// Next state
// ----------------------------------------------------------------
always_comb begin
    d = q;
    d.pins.cmd = CMD_NOP;
    d.pins.dqm = 4'h0;
    d.dq_oe = 1'b0;
    d.rd_valid = 1'b0;
    d.rd_pipe = {q.rd_pipe[CAS_LAT-1:0], 1'b0};
    if (q.rd_pipe[CAS_LAT]) begin
        d.rd_data = dq_in;
        d.rd_valid = 1'b1;
    end
    if (q.wait_cnt != '0) begin
        d.wait_cnt = q.wait_cnt - WW'(1);
    end
    d.trrd = tdec(q.trrd);
    d.bt = bt_dec;
    case (q.st)
        S_PWRUP: begin
            // Power-up pause, then close all banks
            if (q.wait_cnt == '0) begin
                d.pins.cmd = CMD_PRE;
                d.pins.addr = 12'h000;
                d.pins.addr[A10_BIT] = 1'b1;
                d.wait_cnt = L_RP;
                d.owed = 2'h2;
                d.st = S_REF;
            end
        end

        S_REF: begin
            if (q.wait_cnt == '0) begin
                if (q.owed != 2'h0) begin
                    d.pins.cmd = CMD_REF;
                    d.owed = q.owed - 2'h1;
                    d.wait_cnt = L_RFC;
                end else if (q.init_done) begin
                    d.st = S_IDLE;
                end else begin
                    d.st = S_MRS;
                end
            end
        end

        S_MRS: begin
            d.pins.cmd = CMD_MRS;
            d.pins.ba = 2'h0;
            d.pins.addr = MODE_WORD;
            d.wait_cnt = L_MRD;
            d.init_done = 1'b1;
            d.st = S_IDLE;
        end

        S_IDLE: begin
            // Idle waits out precharge and mode-load spacing
            if (q.wait_cnt == '0) begin
                if (q.owed != 2'h0) begin
                    d.st = S_REF;
                end else if (sref_req) begin
                    d.pins.cmd = CMD_REF;
                    d.pins.cke = 1'b0;
                    d.wait_cnt = L_SRMIN;
                    d.st = S_SREF;
                end else if (req_valid && req_ready) begin
                    d.pins.cmd = CMD_ACT;
                    d.pins.ba = req.bank;
                    d.pins.addr = req.row;
                    d.bank = req.bank;
                    d.write = req.write;
                    d.dq_o = req.wdata;
                    d.pins.dqm = 4'h0;
                    d.bt[req.bank].rc = L_RC;
                    d.bt[req.bank].ras = L_RAS;
                    d.bt[req.bank].rcd = L_RCD;
                    d.trrd = L_RRD;
                    d.st = S_RW;
                end
            end
        end

        S_RW: begin
            if (q.bt[q.bank].rcd == '0) begin
                d.pins.ba = q.bank;
                d.pins.addr = {3'h0, req_col_q};
                if (q.write) begin
                    d.pins.cmd = CMD_WR;
                    d.dq_oe = 1'b1;
                    d.pins.dqm = mask_q;
                    d.bt[q.bank].dpl = L_DPL;
                    d.bt[q.bank].dal = L_DAL;
                end else begin
                    d.pins.cmd = CMD_RD;
                    d.rd_pipe[0] = 1'b1;
                end
                d.st = S_PRE;
            end
        end

        S_PRE: begin
            // Single word bursts end alone, so no burst stop is needed
            if ((q.bt[q.bank].ras == '0) &&
                (q.bt[q.bank].dpl == '0)) begin
                d.pins.cmd = CMD_PRE;
                d.pins.ba = q.bank;
                d.pins.addr = 12'h000;
                d.wait_cnt = L_RP;
                d.st = S_IDLE;
            end
        end

        S_SREF: begin
            // Device refreshes itself, so nothing is owed here
            d.owed = 2'h0;
            if ((q.wait_cnt == '0) && !sref_req) begin
                d.pins.cke = 1'b1;
                d.wait_cnt = L_XSR;
                d.st = S_SRX;
            end
        end

        S_SRX: begin
            if (q.wait_cnt == '0) begin
                d.st = S_IDLE;
            end
        end

        default: begin
            d.st = S_PWRUP;
        end
    endcase

    // Tick applied after consumption so a tick is not lost to a same-cycle refresh; owed saturates at two and ticks in S_SREF are dropped
    if (q.ref_cnt == '0) begin
        d.ref_cnt = RST_REF;
        if (q.st != S_SREF) begin
            d.owed = (d.owed == 2'h0) ? 2'h1 : 2'h2;
        end
    end else begin
        d.ref_cnt = q.ref_cnt - RW'(1);
    end
end

// ----------------------------------------------------------------
// Request column and mask hold
// ----------------------------------------------------------------
// Held outside the state word: only the accepted request's copy matters

always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
        req_col_q <= 9'h000;
        mask_q <= 4'h0;
    end else if (req_valid && req_ready) begin
        req_col_q <= req.col;
        mask_q <= req.mask;
    end
end

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
        q <= '0;
        q.st <= S_PWRUP;
        q.wait_cnt <= WW'(INIT_CYCLES - 1);
        q.ref_cnt <= RST_REF;
        q.pins.cke <= 1'b1;
        q.pins.cmd <= CMD_NOP;
    end else begin
        q <= d;
    end
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
assign pins = q.pins;
assign dq_o = q.dq_o;
assign dq_oe = q.dq_oe;
assign rd_data = q.rd_data;
assign rd_valid = q.rd_valid;
assign init_done = q.init_done;
assign sref_active = (q.st == S_SREF);

endmodule

// file: bench/lps_ctrl_properties.sv
// Concurrent checks on the host sequencer pins
`timescale 1ns/1ps
module lps_ctrl_chk
    import lps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire lps_pins_t pins,
    input wire logic dq_oe,
    input wire logic init_done
);
// ----
// Ages and checks
// ----
logic [4:0] act_age_q [NBANK];
logic [4:0] cke_age_q;
lps_cmd_t c;
assign c = pins.cmd;
// Ages saturate so an old command never wraps into a false hit
always_ff @(posedge clk_sys) begin
    cke_age_q <= !rst_n ? 5'h1f : !pins.cke ? 5'h00
        : cke_age_q + 5'(cke_age_q != 5'h1f);
    for (int b = 0; b < NBANK; b++) begin
        act_age_q[b] <= !rst_n ? 5'h1f
            : (c == CMD_ACT && pins.ba == 2'(b)) ? 5'h01
            : act_age_q[b] + 5'(act_age_q[b] != 5'h1f);
    end
end
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
AST_INIT_FIRST: assert property (
    !init_done |-> !(c inside {CMD_ACT, CMD_RD, CMD_WR}))
    else $error("access before init");
AST_LEGAL_CMD: assert property (
    c inside {CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_NOP})
    else $error("undefined command");
AST_ROW_OPEN: assert property (
    c == CMD_PRE && !pins.addr[A10_BIT] |-> act_age_q[pins.ba] >= 5'd10)
    else $error("row closed early");
AST_SAME_BANK: assert property (
    c == CMD_ACT |-> act_age_q[pins.ba] >= 5'd12)
    else $error("same bank activates too close");
AST_ACT_COL: assert property (
    c == CMD_ACT |=> (!(c inside {CMD_RD, CMD_WR}))[*3])
    else $error("column command too early");
AST_ANY_BANK: assert property (
    c == CMD_ACT |=> (c != CMD_ACT)[*2])
    else $error("activates too close");
AST_SREF_EXIT: assert property (
    c == CMD_ACT |-> cke_age_q >= 5'd16)
    else $error("activate too soon after wake");
AST_WR_DATA: assert property (
    dq_oe == (c == CMD_WR))
    else $error("write data not with write");
AST_DATA_ACT: assert property (
    c == CMD_WR |=> (c != CMD_ACT)[*4])
    else $error("activate too soon after data");
AST_DATA_PRE: assert property (
    c == CMD_WR |=> c != CMD_PRE)
    else $error("precharge too soon after data");
AST_MODE_GAP: assert property (
    c == CMD_MRS |=> !(c inside {CMD_ACT, CMD_REF}))
    else $error("command too soon after mode load");
cover property (c == CMD_WR);
cover property (c == CMD_RD);
cover property ($fell(pins.cke));
endmodule
bind lps_ctrl lps_ctrl_chk u_lps_ctrl_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .pins(pins), .dq_oe(dq_oe), .init_done(init_done));

// file: bench/lps_dev.sv
// Behavioural SDRAM device answering the host sequencer
`timescale 1ns/1ps
module lps_dev
    import lps_pkg::*;
(
    input wire logic clk_sys,
    input wire lps_pins_t pins,
    input wire logic [31:0] dq_o,
    input wire logic dq_oe,
    output logic [31:0] dq_in
);
// ----
// Array, open rows and read pipe
// ----
logic [31:0] mem [int];
logic [11:0] row_q [NBANK];
logic [31:0] pd_q [3];
logic [2:0] vd_q = '0;
logic [7:0] md_q = '0;
logic [31:0] last_q = '0;
logic cke_q = 1'b1;
int k;
// Released bus flips each cycle so a stale word never passes
always_comb begin
    for (int b = 0; b < 4; b++) begin
        dq_in[8*b+:8] = dq_oe ? dq_o[8*b+:8]
            : (vd_q[2] && !md_q[4+b]) ? pd_q[2][8*b+:8]
            : ~last_q[8*b+:8];
    end
end
always @(posedge clk_sys) begin
    k = int'({pins.ba, row_q[pins.ba], pins.addr[8:0]});
    last_q <= dq_in;
    cke_q <= pins.cke;
    md_q <= {md_q[3:0], pins.dqm};
    vd_q <= {vd_q[1:0], 1'b0};
    pd_q[1] <= pd_q[0];
    pd_q[2] <= pd_q[1];
    if (cke_q && pins.cke) begin
        if (pins.cmd == CMD_ACT) row_q[pins.ba] <= pins.addr;
        if (!mem.exists(k)) mem[k] = '0;
        for (int b = 0; b < 4; b++) begin
            if (pins.cmd == CMD_WR && !pins.dqm[b]) begin
                mem[k][8*b+:8] = dq_in[8*b+:8];
            end
        end
        if (pins.cmd == CMD_RD) vd_q[0] <= 1'b1;
        pd_q[0] <= mem[k];
    end
end
endmodule

// file: bench/lps_ctrl_bench.sv
// Self-checking bench for the SDRAM host sequencer
`timescale 1ns/1ps
module lps_ctrl_bench
    import lps_pkg::*;
;
// ----
// Stimulus, model and checks
// ----
localparam int INIT = 20;
logic clk_sys = 1'b0;
logic rst_n = 1'b0;
logic req_valid = 1'b0;
lps_req_t req = '0;
logic sref_req = 1'b0;
logic req_ready, rd_valid, sref_active, init_done, dq_oe;
logic [31:0] rd_data, dq_o, dq_in, w_d;
logic [3:0] w_m;
lps_pins_t pins;
logic [31:0] seed = 32'h45;
logic [31:0] mem_e [int];
logic [31:0] rq [$];
int error_cnt = 0;
int checks = 0;
int ref_n = 0;
always #2.5 clk_sys = ~clk_sys;
lps_ctrl #(.INIT_CYCLES(INIT)) u_lps_ctrl (.clk_sys(clk_sys),
    .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .sref_req(sref_req), .sref_active(sref_active),
    .init_done(init_done), .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_in(dq_in));
lps_dev u_lps_dev (.clk_sys(clk_sys), .pins(pins), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_in(dq_in));
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
        error_cnt++;
        $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
endtask
task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask
// Closed page: one request in flight, so the model is a plain map
task automatic access(input logic wr, input logic [1:0] bk,
    input logic [11:0] rw, input logic [8:0] cl, input logic [31:0] d,
    input logic [3:0] m);
    int k;
    int n;
    k = int'({bk, rw, cl});
    n = 0;
    @(posedge clk_sys);
    req <= '{wr, bk, rw, cl, d, m};
    req_valid <= 1'b1;
    do begin
        @(negedge clk_sys);
        n++;
    end while (req_ready !== 1'b1 && n < 4000);
    if (n >= 4000) error_cnt++;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    if (wr) {w_d, w_m} = {d, m};
    if (!mem_e.exists(k)) mem_e[k] = '0;
    for (int b = 0; b < 4; b++) begin
        if (wr && !m[b]) mem_e[k][8*b+:8] = d[8*b+:8];
    end
    if (!wr) rq.push_back(mem_e[k]);
endtask
task automatic do_reset();
    lps_cmd_t q [$];
    int n;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({pins.cmd, pins.cke, dq_oe, init_done, rd_valid, req_ready},
        9'h0f0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    n = 0;
    while (init_done !== 1'b1 && n < 500) begin
        @(negedge clk_sys);
        n++;
        if (pins.cmd != CMD_NOP) q.push_back(pins.cmd);
        if (pins.cmd == CMD_PRE) chk({n > INIT, pins.addr[A10_BIT]}, 2'h3);
    end
    chk({8'(q.size()), pins.addr, q[0], q[1], q[2], q[3]}, {8'd4, MODE_WORD,
        CMD_PRE, CMD_REF, CMD_REF, CMD_MRS});
    $display("test reset done");
endtask
always @(negedge clk_sys) begin
    if (pins.cmd == CMD_REF && pins.cke) ref_n++;
    if (pins.cmd == CMD_WR) chk({dq_o, pins.dqm}, {w_d, w_m});
    if (rd_valid === 1'b1) chk(rd_data, rq.size() ? rq.pop_front() : 'x);
end
initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    conclude();
end
initial begin
    logic [31:0] r;
    int n;
    do_reset();
    for (int i = 0; i < 48; i++) begin
        r = rnd();
        access(r[0], r[2:1], {10'h0, r[4:3]}, {7'h0, r[6:5]}, rnd(), r[10:7]);
    end
    $display("test random_access done");
    for (int m = 0; m < 16; m++) begin
        access(1'b1, 2'(m), 12'h7, 9'h3, rnd(), 4'(m));
        access(1'b0, 2'(m), 12'h7, 9'h3, '0, '0);
    end
    $display("test byte_mask done");
    sref_req <= 1'b1;
    n = 0;
    while (sref_active !== 1'b1 && n < 200) begin
        @(negedge clk_sys);
        n++;
    end
    repeat (30) begin
        @(negedge clk_sys);
        chk({pins.cke, req_ready, sref_active}, 3'h1);
    end
    @(posedge clk_sys);
    sref_req <= 1'b0;
    access(1'b0, 2'h2, 12'h7, 9'h3, '0, '0);
    $display("test self_refresh done");
    n = ref_n;
    repeat (3200) @(posedge clk_sys);
    chk(ref_n > n, 1'b1);
    $display("test refresh done");
    do_reset();
    access(1'b0, 2'h1, 12'h7, 9'h3, '0, '0);
    repeat (12) @(posedge clk_sys);
    chk(rq.size(), 0);
    $display("test reset_again done");
    conclude();
end
endmodule
